// >>> tap_pin_share.sv
// test-pin sharing control: selects test or user duty for shared pins
// Notes on behaviour
// R01: in flexible mode the test clock, data in and data out pins become test pins once TMS goes low.
// R02: once in test duty the shared pins stay test pins in every state until Test-Logic-Reset.
// R03: on entering Test-Logic-Reset the shared pins return to user I/O.
// R04: five test clocks with TMS high put the controller into Test-Logic-Reset.
// R05: in dedicated mode TMS behaves as the standard prescribes with no pin sharing.
// R06: a reserved test reset pin held low resets the controller asynchronously of the test clock.
// R07: without the reset reservation the reset pin is user I/O with no reset effect.
// R08: at power-up the controller starts in Test-Logic-Reset so flexible pins begin as user I/O.
// R09: in flexible mode the change to test duty happens on a rising test clock with TMS low.
// R10: in dedicated mode all test pins are always test pins whatever the state.
// R11: the controller follows the sixteen-state graph on each rising test clock.
`timescale 1ns/1ps
module tap_pin_share
    import tap_pin_pkg::*;
#(
    parameter bit DEDICATED = 1'b0,
    parameter bit RESERVE_TRST = 1'b0
) (
    // system clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // test link
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic i_trst_n,
    // pin duty, system domain
    output logic o_test_duty,
    output logic o_trst_is_user,
    output logic o_in_reset_state
);
    import tap_pin_pkg::*;

    // true when this state and select value lead into Test-Logic-Reset
    function automatic logic enters_reset(input tap_state_t state, input logic tms);
        return tms && (state == TAP_RESET || state == TAP_SEL_IR);
    endfunction : enters_reset

    tap_state_t tap_state;
    logic por_q;
    logic trst_en;
    logic trst_n_eff;
    logic link_rst_n;
    logic in_reset_tck_q;
    logic [2:0] tms_hi_q;
    logic [SYNC_STAGES-1:0] rst_sync_q;
    logic in_reset_sync;

    // power-up: the system reset also holds the link side, so the controller
    // starts in Test-Logic-Reset; the test clock must be idle at its release
    always_ff @(posedge i_clk) begin
        por_q <= i_rst; // R08
    end

    // the test reset pin acts only when reserved; power-up reset always acts
    assign trst_en = RESERVE_TRST | por_q; // R06 R07
    assign trst_n_eff = i_trst_n & ~por_q; // R06 R08
    assign link_rst_n = trst_n_eff | ~trst_en; // R06 R07

    tap_fsm u_fsm (
        .i_tck(i_tck),
        .i_trst_n(trst_n_eff),
        .i_trst_en(trst_en),
        .i_tms(i_tms),
        .o_state(tap_state)
    );

    // a lone registered flag is safe to carry across; a decode of the state
    // bits could glitch through Test-Logic-Reset between two other states
    always_ff @(posedge i_tck or negedge link_rst_n) begin
        if (!link_rst_n) begin
            in_reset_tck_q <= 1'b1; // R06 R08
        end else begin
            in_reset_tck_q <= enters_reset(tap_state, i_tms); // R02 R03 R09 R11
        end
    end

    // run of high select samples, kept for the checks only
    always_ff @(posedge i_tck or negedge link_rst_n) begin
        if (!link_rst_n) begin
            tms_hi_q <= 3'h0;
        end else if (!i_tms) begin
            tms_hi_q <= 3'h0;
        end else if (tms_hi_q != 3'h7) begin
            tms_hi_q <= tms_hi_q + 3'h1;
        end
    end

    // two-flop crossing into the system clock, reset to Test-Logic-Reset
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rst_sync_q <= '1;
        end else begin
            rst_sync_q <= {rst_sync_q[SYNC_STAGES-2:0], in_reset_tck_q};
        end
    end

    assign in_reset_sync = rst_sync_q[SYNC_STAGES-1];

    // flexible pins follow the controller; dedicated pins never leave test duty
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_test_duty <= DEDICATED; // R08 R10
        end else begin
            o_test_duty <= DEDICATED | ~in_reset_sync; // R01 R02 R03 R05 R10
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_in_reset_state <= 1'b1; // R08
        end else begin
            o_in_reset_state <= in_reset_sync; // R11
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_trst_is_user <= ~RESERVE_TRST; // R07
        end else begin
            o_trst_is_user <= ~RESERVE_TRST; // R07
        end
    end

    // link-side checks
    AST_LINK_DUTY: assert property (@(posedge i_tck) disable iff (!link_rst_n) // R01
        (tap_state == TAP_IDLE) |-> !in_reset_tck_q)
    else begin
        $error("idle state without test duty");
    end
    AST_FLAG_MATCHES_STATE: assert property (@(posedge i_tck) disable iff (!link_rst_n) // R02
        in_reset_tck_q == (tap_state == TAP_RESET))
    else begin
        $error("link flag disagrees with controller state");
    end
    AST_FLAG_SETS: assert property (@(posedge i_tck) disable iff (!link_rst_n) // R03
        enters_reset(tap_state, i_tms) |=> in_reset_tck_q)
    else begin
        $error("link flag missed entry to reset state");
    end
    AST_FLAG_CLEARS: assert property (@(posedge i_tck) disable iff (!link_rst_n) // R02
        !enters_reset(tap_state, i_tms) |=> !in_reset_tck_q)
    else begin
        $error("link flag set outside reset state");
    end
    AST_LOW_TMS_TAKES_PINS: assert property (@(posedge i_tck) disable iff (!link_rst_n) // R09
        (in_reset_tck_q && !i_tms) |=> !in_reset_tck_q)
    else begin
        $error("low select did not take the pins");
    end
    AST_FLAG_FIVE_HIGH: assert property (@(posedge i_tck) disable iff (!link_rst_n) // R04
        (tms_hi_q >= 3'(RESET_TMS_HIGH_CYCLES)) |-> in_reset_tck_q)
    else begin
        $error("five high select cycles left pins in test duty");
    end

    // system-side checks
    AST_DEDICATED_ALWAYS: assert property (@(posedge i_clk) disable iff (i_rst) // R10
        DEDICATED |-> o_test_duty)
    else begin
        $error("dedicated mode lost test duty");
    end
    AST_DUTY_FOLLOWS: assert property (@(posedge i_clk) disable iff (i_rst) // R02
        !$past(in_reset_sync) |-> o_test_duty)
    else begin
        $error("test duty dropped while link held it");
    end
    AST_RELEASE_USER: assert property (@(posedge i_clk) disable iff (i_rst) // R03
        (!DEDICATED && in_reset_sync) |=> !o_test_duty)
    else begin
        $error("pins not released to user duty");
    end
    AST_TRST_USER: assert property (@(posedge i_clk) disable iff (i_rst) // R07
        o_trst_is_user == !RESERVE_TRST)
    else begin
        $error("reset pin role wrong");
    end
    AST_POWERUP_RESET: assert property (@(posedge i_clk) disable iff (i_rst) // R08
        $past(i_rst) |-> o_in_reset_state)
    else begin
        $error("controller not in reset state after power-up");
    end
    AST_RESET_VALUES: assert property (@(posedge i_clk) // R08
        i_rst |=> (o_in_reset_state && o_test_duty == DEDICATED))
    else begin
        $error("outputs wrong during reset");
    end
    AST_OUTPUTS_AGREE: assert property (@(posedge i_clk) disable iff (i_rst) // R05
        o_test_duty == (DEDICATED || !o_in_reset_state))
    else begin
        $error("test duty and reset state disagree");
    end
    AST_ENTER_LATENCY: assert property (@(posedge i_clk) disable iff (i_rst) // R09
        (!DEDICATED && $fell(in_reset_sync)) |=> o_test_duty)
    else begin
        $error("test duty late after leaving reset state");
    end
    AST_LEAVE_LATENCY: assert property (@(posedge i_clk) disable iff (i_rst) // R03
        (!DEDICATED && $rose(in_reset_sync)) |=> !o_test_duty)
    else begin
        $error("user duty late after entering reset state");
    end

    // reset glue checks
    AST_TRST_ACTS: assert property (@(posedge i_clk) // R06
        (RESERVE_TRST && !i_trst_n) |-> !link_rst_n)
    else begin
        $error("reserved reset pin did not reset the link side");
    end
    AST_TRST_IGNORED: assert property (@(posedge i_clk) // R07
        (!RESERVE_TRST && !por_q) |-> link_rst_n)
    else begin
        $error("unreserved reset pin reset the link side");
    end
    AST_POR_HOLDS_LINK: assert property (@(posedge i_clk) // R08
        por_q |-> (!link_rst_n && in_reset_tck_q))
    else begin
        $error("power-up reset did not hold the link side");
    end

    COV_ENTER_TEST: cover property (@(posedge i_clk) $rose(o_test_duty));
    COV_LEAVE_TEST: cover property (@(posedge i_clk) $fell(o_test_duty));
    COV_SHIFT_DR: cover property (@(posedge i_tck) tap_state == TAP_SHIFT_DR);
    COV_FIVE_HIGH: cover property (@(posedge i_tck) tms_hi_q == 3'(RESET_TMS_HIGH_CYCLES));
    COV_TRST_PULSE: cover property (@(posedge i_clk) RESERVE_TRST && !i_trst_n && !por_q);
endmodule : tap_pin_share

// >>> tap_pin_pkg.sv
// shared constants and types for the test-pin sharing block
package tap_pin_pkg;
    typedef enum logic [3:0] {
        TAP_RESET,
        TAP_IDLE,
        TAP_SEL_DR,
        TAP_CAP_DR,
        TAP_SHIFT_DR,
        TAP_EXIT1_DR,
        TAP_PAUSE_DR,
        TAP_EXIT2_DR,
        TAP_UPD_DR,
        TAP_SEL_IR,
        TAP_CAP_IR,
        TAP_SHIFT_IR,
        TAP_EXIT1_IR,
        TAP_PAUSE_IR,
        TAP_EXIT2_IR,
        TAP_UPD_IR
    } tap_state_t;

    localparam int RESET_TMS_HIGH_CYCLES = 5;
    localparam int SYNC_STAGES = 2;
endpackage : tap_pin_pkg

// >>> tap_fsm.sv
// sixteen-state test access port controller on the test clock
`timescale 1ns/1ps
module tap_fsm
    import tap_pin_pkg::*;
(
    // link clock and pins
    input wire logic i_tck,
    input wire logic i_trst_n,
    input wire logic i_trst_en,
    input wire logic i_tms,
    // state out
    output tap_pin_pkg::tap_state_t o_state
);
    import tap_pin_pkg::*;

    tap_state_t state_q;
    tap_state_t state_d;
    logic arst_n;

    // the reset pin only acts when reserved for test use
    assign arst_n = i_trst_n | ~i_trst_en; // R06 R07

    always_comb begin
        state_d = state_q;
        case (state_q) // R11
            TAP_RESET: state_d = i_tms ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: state_d = i_tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: state_d = i_tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: state_d = i_tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: state_d = i_tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: state_d = i_tms ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: state_d = i_tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: state_d = i_tms ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: state_d = i_tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: state_d = i_tms ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: state_d = i_tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: state_d = i_tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: state_d = i_tms ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: state_d = i_tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: state_d = i_tms ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: state_d = i_tms ? TAP_SEL_DR : TAP_IDLE;
            default: state_d = TAP_RESET;
        endcase
    end

    // power-up reset and test reset both arrive on the asynchronous reset
    always_ff @(posedge i_tck or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= TAP_RESET; // R06
        end else begin
            state_q <= state_d; // R11
        end
    end

    assign o_state = state_q;

    // five high TMS cycles reach Test-Logic-Reset from any state
    logic [2:0] hi_cnt_q;
    always_ff @(posedge i_tck or negedge arst_n) begin
        if (!arst_n) begin
            hi_cnt_q <= 3'h0;
        end else if (!i_tms) begin
            hi_cnt_q <= 3'h0;
        end else if (hi_cnt_q != 3'h7) begin
            hi_cnt_q <= hi_cnt_q + 3'h1;
        end
    end

    AST_FIVE_TMS_HIGH: assert property (@(posedge i_tck) disable iff (!arst_n) // R04
        (hi_cnt_q >= 3'(RESET_TMS_HIGH_CYCLES)) |-> (state_q == TAP_RESET))
        else $error("five high tms cycles did not reach reset");
    AST_TMS_LOW_LEAVES: assert property (@(posedge i_tck) disable iff (!arst_n) // R11
        (state_q == TAP_RESET && !i_tms) |=> (state_q == TAP_IDLE))
        else $error("low tms did not leave reset state");
    AST_TMS_HIGH_STAYS: assert property (@(posedge i_tck) disable iff (!arst_n) // R11
        (state_q == TAP_RESET && i_tms) |=> (state_q == TAP_RESET))
        else $error("reset state left with tms high");
endmodule : tap_fsm

// >>> tap_ctrl_model.sv
// boundary-scan test controller model driving the link pins
`timescale 1ns/1ps
module tap_ctrl_model (
    // link pins
    output logic o_tck,
    output logic o_tms,
    output logic o_trst_n
);
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_trst_n = 1'b1;
    end
    // one 12 ns test clock; the clock stands still between steps
    task automatic step(input logic tms_v);
        o_tms = tms_v;
        #6 o_tck = 1'b1;
        #6 o_tck = 1'b0;
        o_tms = 1'b1;
    endtask : step
    // reset pin pulsed low while the test clock is stopped
    task automatic pulse_reset();
        o_trst_n = 1'b0;
        #30 o_trst_n = 1'b1;
    endtask : pulse_reset
endmodule : tap_ctrl_model

// >>> jtag_pin_sharing_control_tb.sv
// self-checking bench for the test-pin sharing block
`timescale 1ns/1ps
module jtag_pin_sharing_control_tb;
    import tap_pin_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic tck, tms, trst_n, duty_f, user_f, rst_f, duty_d, user_d, rst_d;
    logic [31:0] r;
    tap_state_t st_f, st_d;
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;
    int seed = 32'h30f9ead4;
    always #20 i_clk = ~i_clk;
    tap_ctrl_model u_tap_ctrl_model (.o_tck(tck), .o_tms(tms), .o_trst_n(trst_n));
    tap_pin_share #(.DEDICATED(1'b0), .RESERVE_TRST(1'b1)) u_tap_pin_share (
        .i_clk(i_clk), .i_rst(i_rst), .i_tck(tck), .i_tms(tms), .i_trst_n(trst_n),
        .o_test_duty(duty_f), .o_trst_is_user(user_f), .o_in_reset_state(rst_f));
    tap_pin_share #(.DEDICATED(1'b1), .RESERVE_TRST(1'b0)) u_tap_pin_share_ded (
        .i_clk(i_clk), .i_rst(i_rst), .i_tck(tck), .i_tms(tms), .i_trst_n(trst_n),
        .o_test_duty(duty_d), .o_trst_is_user(user_d), .o_in_reset_state(rst_d));
    function automatic tap_state_t nxt(input tap_state_t s, input logic t);
        case (s)
            TAP_RESET: return t ? TAP_RESET : TAP_IDLE;
            TAP_IDLE, TAP_UPD_DR, TAP_UPD_IR: return t ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: return t ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_SEL_IR: return t ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_DR, TAP_SHIFT_DR: return t ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_CAP_IR, TAP_SHIFT_IR: return t ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_DR: return t ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_EXIT1_IR: return t ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_DR: return t ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_PAUSE_IR: return t ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_DR: return t ? TAP_UPD_DR : TAP_SHIFT_DR;
            default: return t ? TAP_UPD_IR : TAP_SHIFT_IR;
        endcase
    endfunction : nxt
    task automatic check(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic settle_and_check();
        repeat (6) @(posedge i_clk);
        #1;
        check(duty_f, st_f != TAP_RESET);
        check(rst_f, st_f == TAP_RESET);
        check(duty_d, 1'b1);
        check(rst_d, st_d == TAP_RESET);
    endtask : settle_and_check
    task automatic tclk(input logic t);
        u_tap_ctrl_model.step(t);
        st_f = nxt(st_f, t);
        st_d = nxt(st_d, t);
        settle_and_check();
    endtask : tclk
    task automatic tally_and_finish();
        $display("comparisons %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : tally_and_finish
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 8000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    initial begin
        st_f = TAP_RESET;
        st_d = TAP_RESET;
        repeat (12) @(posedge i_clk);
        #1 i_rst = 1'b0;
        settle_and_check();
        check(user_f, 1'b0);
        check(user_d, 1'b1);
        tclk(1'b0);
        for (int i = 0; i < 5; i++) tclk(1'b1);
        for (int i = 0; i < 300; i++) begin
            r = $random(seed);
            tclk(r[0]);
        end
        for (int i = 3; i >= 0; i--) tclk(i != 1);
        for (int i = 0; i < 5; i++) tclk(1'b1);
        check(rst_f, 1'b1);
        for (int i = 0; i < 4; i++) tclk(i == 1);
        u_tap_ctrl_model.pulse_reset();
        st_f = TAP_RESET;
        settle_and_check();
        tally_and_finish();
    end
endmodule : jtag_pin_sharing_control_tb
